/* File: common/aux_irq_pkg.sv */
// package: offsets, field positions, reset values, carrier types for the flag block
// assumes a 40 MHz pclk and an APB master with 32-bit data
package aux_irq_pkg;
	localparam int secondary_irq_flags_index = 5;
	localparam int error_flags_index = 6;
	localparam int secondary_enable_index = 3;
	localparam logic [11:0] secondary_irq_flags_offset = 12'(secondary_irq_flags_index * 4);
	localparam logic [11:0] error_flags_offset = 12'(error_flags_index * 4);
	localparam logic [11:0] secondary_enable_offset = 12'(secondary_enable_index * 4);
	localparam logic [11:0] command_status_offset = 12'h040;
	localparam logic [11:0] control_offset = 12'h044;
	localparam int set_clear_pos = 7;
	localparam int signal_in_pos = 4;
	localparam int mode_det_pos = 3;
	localparam int crc_done_pos = 2;
	localparam int field_on_pos = 1;
	localparam int field_off_pos = 0;
	localparam int write_err_pos = 7;
	localparam int temp_err_pos = 6;
	localparam int rf_err_pos = 5;
	localparam int ovfl_pos = 4;
	localparam int coll_pos = 3;
	localparam int crc_err_pos = 2;
	localparam int parity_pos = 1;
	localparam int protocol_pos = 0;
	localparam logic [7:0] irq_writable_mask = 8'h1f;
	localparam logic [7:0] irq_reset = 8'h00;
	localparam logic [7:0] error_reset = 8'h00;
	localparam logic [7:0] enable_reset = 8'h00;
	localparam logic [1:0] framing_rf_check = 2'h1;
	localparam logic [1:0] rate_106 = 2'h0;

	// event strobes from the transceiver, one pclk pulse each except levels field_present, fifo_full, in_response_window, active_mode, passive_high_rate
	typedef struct packed {
		logic mode_found;
		logic crc_all_consumed;
		logic field_present;
		logic rf_reset;
		logic command_start;
		logic anticoll_start;
		logic host_fifo_write;
		logic fifo_full;
		logic internal_fifo_write;
		logic in_response_window;
		logic overheat;
		logic peer_field_late;
		logic active_mode;
		logic receiver_start;
		logic bit_collision;
		logic crc_failed;
		logic parity_failed;
		logic sof_bad;
		logic byte_length_bad;
		logic auth_count_bad;
		logic miller_pulse_close;
		logic passive_high_rate;
	} event_in_type;

	// settings held elsewhere in the device
	typedef struct packed {
		logic [1:0] rate;
		logic receive_crc_check_enable;
		logic sync_detection_enable;
		logic initiator;
		logic [1:0] receive_framing_field;
		logic [1:0] transmit_framing_field;
		logic auto_anticollision_command;
		logic authentication_command;
		logic crc_command;
	} config_in_type;
endpackage

/* File: design/aux_irq_and_error_flags.sv */
// secondary request flags, error flags and summary interrupt, apb slave
// assumes strobes are synchronous to pclk except the secure element input
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module aux_irq_and_error_flags
	import aux_irq_pkg::*;
(
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// events and settings
	input wire logic secure_element_signal_input,
	input wire event_in_type ev,
	input wire config_in_type cfg,
	input wire logic primary_request,
	// results
	output logic mode_detector_running,
	output logic antenna_drivers_off,
	output logic irq
);

	// ==========================================================
	// bus decode
	logic wr_en;
	logic rd_en;
	logic [7:0] wbyte;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite; // read data latched in setup
	assign wbyte = pwdata[7:0];
	assign pready = 1'b1;

	function automatic logic mapped(input logic [11:0] a);
		mapped = (a == secondary_irq_flags_offset) || (a == error_flags_offset) ||
			(a == secondary_enable_offset) || (a == command_status_offset) ||
			(a == control_offset);
	endfunction

	assign pslverr = psel && penable && !mapped(paddr);

	// ==========================================================
	// signal input synchroniser and edge detect
	logic sig_meta;
	logic sig_sync;
	logic sig_last;
	logic sig_edge;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sig_meta <= 1'b0;
			sig_sync <= 1'b0;
			sig_last <= 1'b0;
		end
		else
		begin
			sig_meta <= secure_element_signal_input;
			sig_sync <= sig_meta;
			sig_last <= sig_sync;
		end
	end
	assign sig_edge = sig_sync ^ sig_last;

	// ==========================================================
	// mode detector run state
	logic mode_hit;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mode_detector_running <= 1'b0;
		else if (ev.anticoll_start || ev.rf_reset)
			mode_detector_running <= 1'b1;
		else if (ev.mode_found)
			mode_detector_running <= 1'b0;
	end
	assign mode_hit = mode_detector_running && ev.mode_found;

	// ==========================================================
	// field edge tracking
	logic field_last;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			field_last <= 1'b0;
		else
			field_last <= ev.field_present;
	end

	// ==========================================================
	// secondary request flags
	logic [7:0] irq_flags;
	logic [7:0] irq_events;
	logic [7:0] next_irq_flags;
	logic irq_wr;
	assign irq_wr = wr_en && (paddr == secondary_irq_flags_offset);

	always_comb
	begin
		irq_events = 8'h00;
		irq_events[signal_in_pos] = sig_edge;
		irq_events[mode_det_pos] = mode_hit;
		irq_events[crc_done_pos] = cfg.crc_command && ev.crc_all_consumed;
		irq_events[field_on_pos] = ev.field_present && !field_last;
		irq_events[field_off_pos] = !ev.field_present && field_last;
		next_irq_flags = irq_flags;
		if (irq_wr)
		begin
			if (wbyte[set_clear_pos])
				next_irq_flags = irq_flags | (wbyte & irq_writable_mask);
			else
				next_irq_flags = irq_flags & ~(wbyte & irq_writable_mask);
		end
		// hardware only ever sets; set wins over a same-cycle clear
		next_irq_flags = next_irq_flags | irq_events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq_flags <= irq_reset;
		else
			irq_flags <= next_irq_flags & irq_writable_mask;
	end

	// ==========================================================
	// secondary enable mask
	logic [7:0] enable_mask;
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			enable_mask <= enable_reset;
		else if (wr_en && paddr == secondary_enable_offset)
			enable_mask <= wbyte & irq_writable_mask;
	end

	// ==========================================================
	// error flags
	logic [7:0] err_flags;
	logic [7:0] err_events;
	logic [7:0] next_err_flags;
	logic is_106;
	logic high_rate;
	logic rf_check_on;
	logic proto_event;
	assign is_106 = (cfg.rate == rate_106);
	assign high_rate = !is_106;
	assign rf_check_on = (cfg.receive_framing_field == framing_rf_check) ||
		(cfg.transmit_framing_field == framing_rf_check);
	assign proto_event = (ev.sof_bad && is_106) ||
		(cfg.sync_detection_enable && ev.byte_length_bad &&
		(ev.passive_high_rate || (ev.active_mode && high_rate))) ||
		(cfg.auto_anticollision_command && cfg.initiator) ||
		(cfg.authentication_command && ev.auth_count_bad) ||
		ev.miller_pulse_close;

	always_comb
	begin
		err_events = 8'h00;
		err_events[write_err_pos] = ev.host_fifo_write && (cfg.auto_anticollision_command ||
			cfg.authentication_command || ev.in_response_window);
		err_events[temp_err_pos] = ev.overheat;
		err_events[rf_err_pos] = ev.active_mode && rf_check_on && ev.peer_field_late;
		err_events[ovfl_pos] = ev.fifo_full && (ev.host_fifo_write || ev.internal_fifo_write);
		err_events[coll_pos] = ev.bit_collision;
		err_events[crc_err_pos] = cfg.receive_crc_check_enable && ev.crc_failed;
		err_events[parity_pos] = ev.parity_failed;
		err_events[protocol_pos] = proto_event;
		next_err_flags = err_flags;
		if (ev.command_start)
			next_err_flags = err_flags & (8'h01 << temp_err_pos);
		if (ev.receiver_start)
		begin
			next_err_flags[coll_pos] = 1'b0;
			next_err_flags[crc_err_pos] = 1'b0;
			next_err_flags[parity_pos] = 1'b0;
			next_err_flags[protocol_pos] = 1'b0;
		end
		next_err_flags = next_err_flags | err_events;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			err_flags <= error_reset;
		else
			err_flags <= next_err_flags;
	end

	assign antenna_drivers_off = err_flags[temp_err_pos];

	// collision reads one at the higher rates
	logic [7:0] err_view;
	always_comb
	begin
		err_view = err_flags;
		if (high_rate)
			err_view[coll_pos] = 1'b1;
	end

	// ==========================================================
	// summary interrupt
	logic secondary_any;
	assign secondary_any = |(irq_flags & enable_mask);
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= secondary_any || primary_request;
	end

	// ==========================================================
	// read data
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h00000000;
		else if (rd_en)
		begin
			if (paddr == secondary_irq_flags_offset)
				prdata <= {24'h000000, irq_flags & irq_writable_mask};
			else if (paddr == error_flags_offset)
				prdata <= {24'h000000, err_view};
			else if (paddr == secondary_enable_offset)
				prdata <= {24'h000000, enable_mask};
			else if (paddr == command_status_offset)
				prdata <= {30'h00000000, mode_detector_running, irq};
			else if (paddr == control_offset)
				prdata <= {31'h00000000, antenna_drivers_off};
			else
				prdata <= 32'h00000000;
		end
	end

	// ==========================================================
	// checks: request flags
	a_reserved_zero: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq_flags[6:5] == 2'b00 && irq_flags[7] == 1'b0)
		else $error("reserved bit set");
	a_set_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq_wr && wbyte[set_clear_pos] |=> ((irq_flags & $past(wbyte) & irq_writable_mask) ==
		($past(wbyte) & irq_writable_mask)))
		else $error("set write lost");
	a_clear_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq_wr && !wbyte[set_clear_pos] && wbyte[field_on_pos] && !irq_events[field_on_pos]
		|=> !irq_flags[field_on_pos])
		else $error("clear write lost");
	a_edge_sets: assert property (
		@(posedge pclk) disable iff (!presetn)
		$changed(sig_sync) |=> irq_flags[signal_in_pos])
		else $error("signal edge missed");
	a_mode_stop: assert property (
		@(posedge pclk) disable iff (!presetn)
		mode_hit && !ev.anticoll_start && !ev.rf_reset
		|=> !mode_detector_running ##0 irq_flags[mode_det_pos])
		else $error("detector not stopped");
	a_mode_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!mode_detector_running && !ev.anticoll_start && !ev.rf_reset |=> !mode_detector_running)
		else $error("detector started alone");
	a_mode_restart: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.rf_reset |=> mode_detector_running)
		else $error("detector not restarted");
	a_crc_done: assert property (
		@(posedge pclk) disable iff (!presetn)
		cfg.crc_command && ev.crc_all_consumed |=> irq_flags[crc_done_pos])
		else $error("crc done missed");
	a_field_on: assert property (
		@(posedge pclk) disable iff (!presetn)
		$rose(ev.field_present) && $past(presetn) |=> irq_flags[field_on_pos])
		else $error("field on missed");
	a_field_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(ev.field_present) && $past(presetn) |=> irq_flags[field_off_pos])
		else $error("field off missed");
	a_flag_sticky: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq_flags[crc_done_pos] && !irq_wr |=> irq_flags[crc_done_pos])
		else $error("flag dropped");
	a_flags_kept: assert property (
		@(posedge pclk) disable iff (!presetn)
		!irq_wr |=> (irq_flags & $past(irq_flags)) == $past(irq_flags))
		else $error("flag cleared without write");

	// ==========================================================
	// checks: summary interrupt
	a_irq_mask: assert property (
		@(posedge pclk) disable iff (!presetn)
		(irq_flags & enable_mask) != 8'h00 |=> irq)
		else $error("enabled flag no irq");
	a_irq_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		(irq_flags & enable_mask) == 8'h00 && !primary_request |=> !irq)
		else $error("masked flag raised irq");
	a_summary_primary: assert property (
		@(posedge pclk) disable iff (!presetn)
		primary_request |=> irq)
		else $error("primary request not shown");
	a_status_irq: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd_en && paddr == command_status_offset |=> prdata[0] == $past(irq))
		else $error("status bit wrong");

	// ==========================================================
	// checks: error flags
	a_cmd_clears: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.command_start && err_events == 8'h00
		|=> (err_flags & 8'hbf) == 8'h00)
		else $error("command start kept error");
	a_err_no_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr_en && paddr == error_flags_offset && err_events == 8'h00 && !ev.command_start &&
		!ev.receiver_start |=> err_flags == $past(err_flags))
		else $error("error flags written");
	a_write_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.host_fifo_write && (cfg.auto_anticollision_command || cfg.authentication_command ||
		ev.in_response_window) |=> err_flags[write_err_pos])
		else $error("write error missed");
	a_temp_off: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.overheat |=> antenna_drivers_off)
		else $error("drivers not off");
	a_rf_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.active_mode && ev.peer_field_late && (cfg.receive_framing_field == framing_rf_check ||
		cfg.transmit_framing_field == framing_rf_check) |=> err_flags[rf_err_pos])
		else $error("rf timing error missed");
	a_rf_passive: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ev.active_mode && !err_flags[rf_err_pos] |=> !err_flags[rf_err_pos])
		else $error("rf timing error outside active mode");
	a_overflow: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.fifo_full && (ev.host_fifo_write || ev.internal_fifo_write) |=> err_flags[ovfl_pos])
		else $error("overflow missed");
	a_coll_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.bit_collision |=> err_flags[coll_pos])
		else $error("collision missed");
	a_coll_high: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd_en && paddr == error_flags_offset && high_rate |=> prdata[coll_pos])
		else $error("collision not one");
	a_crc_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		cfg.receive_crc_check_enable && ev.crc_failed |=> err_flags[crc_err_pos])
		else $error("crc error missed");
	a_rx_start: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.receiver_start && err_events[3:0] == 4'h0 |=> err_flags[3:0] == 4'h0)
		else $error("receiver start kept error");
	a_parity_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.parity_failed |=> err_flags[parity_pos])
		else $error("parity error missed");
	a_sof_err: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.sof_bad && cfg.rate == rate_106 |=> err_flags[protocol_pos])
		else $error("frame start error missed");
	a_sync_len: assert property (
		@(posedge pclk) disable iff (!presetn)
		cfg.sync_detection_enable && ev.byte_length_bad && (ev.passive_high_rate ||
		(ev.active_mode && cfg.rate != rate_106)) |=> err_flags[protocol_pos])
		else $error("byte length error missed");
	a_initiator: assert property (
		@(posedge pclk) disable iff (!presetn)
		cfg.auto_anticollision_command && cfg.initiator |=> err_flags[protocol_pos])
		else $error("initiator error missed");
	a_auth_count: assert property (
		@(posedge pclk) disable iff (!presetn)
		cfg.authentication_command && ev.auth_count_bad |=> err_flags[protocol_pos])
		else $error("byte count error missed");
	a_miller: assert property (
		@(posedge pclk) disable iff (!presetn)
		ev.miller_pulse_close |=> err_flags[protocol_pos])
		else $error("pulse spacing error missed");
endmodule

/* File: testbench/aux_irq_and_error_flags_tb.sv */
// self-checking bench: apb tasks, event strobes, register and port compares
// assumes the flag package and design module are compiled first
`timescale 1ns/1ps
module aux_irq_and_error_flags_tb;
	import aux_irq_pkg::*;
	// apb
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	// events and results
	logic se_in, primary_request, running, drv_off, irq;
	event_in_type ev, lvl;
	config_in_type cfg;
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;

	aux_irq_and_error_flags dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .secure_element_signal_input(se_in), .ev(ev), .cfg(cfg),
		.primary_request(primary_request), .mode_detector_running(running),
		.antenna_drivers_off(drv_off), .irq(irq));

	// ==========================================
	// tasks
	task automatic test_done();
		$display("checked %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	// entered just after a rising edge; leaves one idle cycle
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic rchk(input string what, input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(what, exp, rd);
	endtask

	// drops pulse fields, keeps levels, lets flag and irq registers land
	task automatic strobe();
		@(posedge pclk);
		ev <= ev & lvl;
		repeat (3) @(posedge pclk);
	endtask

	// ==========================================
	// clock, timeout
	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	always @(posedge pclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			test_done();
		end
	end

	// ==========================================
	// sequence
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		se_in = 1'b0;
		primary_request = 1'b0;
		ev = '0;
		cfg = '0;
		lvl = '0;
		lvl.field_present = 1'b1;
		lvl.fifo_full = 1'b1;
		lvl.in_response_window = 1'b1;
		lvl.active_mode = 1'b1;
		lvl.passive_high_rate = 1'b1;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk("flags reset", secondary_irq_flags_offset, 32'h0);
		rchk("errors reset", error_flags_offset, 32'h0);
		rchk("enable reset", secondary_enable_offset, 32'h0);
		apb(1'b1, secondary_irq_flags_offset, 32'hff);
		rchk("set all", secondary_irq_flags_offset, 32'h1f);
		apb(1'b1, secondary_irq_flags_offset, 32'h0a);
		rchk("clear some", secondary_irq_flags_offset, 32'h15);
		apb(1'b1, secondary_irq_flags_offset, 32'h1f);
		rchk("clear all", secondary_irq_flags_offset, 32'h0);
		se_in <= 1'b1;
		repeat (5) @(posedge pclk);
		rchk("rise edge", secondary_irq_flags_offset, 32'h10);
		cfg.auto_anticollision_command <= 1'b1;
		ev.anticoll_start <= 1'b1;
		strobe();
		check("detector on", 32'h1, {31'h0, running});
		ev.mode_found <= 1'b1;
		strobe();
		check("detector off", 32'h0, {31'h0, running});
		ev.rf_reset <= 1'b1;
		strobe();
		check("restart", 32'h1, {31'h0, running});
		rchk("mode flag", secondary_irq_flags_offset, 32'h18);
		cfg.crc_command <= 1'b1;
		ev.crc_all_consumed <= 1'b1;
		strobe();
		ev.field_present <= 1'b1;
		strobe();
		rchk("crc field on", secondary_irq_flags_offset, 32'h1e);
		ev.field_present <= 1'b0;
		strobe();
		apb(1'b1, secondary_irq_flags_offset, 32'h10);
		se_in <= 1'b0;
		repeat (20) @(posedge pclk);
		rchk("fall off kept", secondary_irq_flags_offset, 32'h1f);
		apb(1'b1, secondary_irq_flags_offset, 32'h1f);
		apb(1'b1, secondary_enable_offset, 32'h04);
		ev.crc_all_consumed <= 1'b1;
		strobe();
		check("irq enabled", 32'h1, {31'h0, irq});
		apb(1'b1, secondary_enable_offset, 32'h0);
		@(posedge pclk);
		check("irq masked", 32'h0, {31'h0, irq});
		primary_request <= 1'b1;
		repeat (3) @(posedge pclk);
		rchk("summary", command_status_offset, 32'h3);
		primary_request <= 1'b0;
		apb(1'b1, error_flags_offset, 32'hff);
		rchk("err no write", error_flags_offset, 32'h0);
		ev.host_fifo_write <= 1'b1;
		strobe();
		cfg.auto_anticollision_command <= 1'b0;
		cfg.receive_crc_check_enable <= 1'b1;
		cfg.receive_framing_field <= framing_rf_check;
		ev.overheat <= 1'b1;
		ev.fifo_full <= 1'b1;
		ev.internal_fifo_write <= 1'b1;
		ev.active_mode <= 1'b1;
		ev.peer_field_late <= 1'b1;
		ev.bit_collision <= 1'b1;
		ev.crc_failed <= 1'b1;
		ev.parity_failed <= 1'b1;
		ev.sof_bad <= 1'b1;
		strobe();
		rchk("all errors", error_flags_offset, 32'hff);
		check("drivers off", 32'h1, {31'h0, drv_off});
		rchk("drivers reg", control_offset, 32'h1);
		ev.command_start <= 1'b1;
		strobe();
		rchk("cmd clears", error_flags_offset, 32'h40);
		cfg.rate <= 2'h1;
		repeat (2) @(posedge pclk);
		rchk("coll high rate", error_flags_offset, 32'h48);
		cfg.sync_detection_enable <= 1'b1;
		ev.byte_length_bad <= 1'b1;
		strobe();
		rchk("sync length", error_flags_offset, 32'h49);
		cfg.rate <= rate_106;
		cfg.sync_detection_enable <= 1'b0;
		cfg.receive_crc_check_enable <= 1'b0;
		cfg.receive_framing_field <= 2'h0;
		ev.fifo_full <= 1'b0;
		ev.bit_collision <= 1'b1;
		ev.crc_failed <= 1'b1;
		ev.parity_failed <= 1'b1;
		ev.peer_field_late <= 1'b1;
		strobe();
		rchk("gated errors", error_flags_offset, 32'h4b);
		cfg.transmit_framing_field <= framing_rf_check;
		ev.receiver_start <= 1'b1;
		ev.peer_field_late <= 1'b1;
		strobe();
		rchk("receiver start", error_flags_offset, 32'h60);
		cfg.authentication_command <= 1'b1;
		ev.auth_count_bad <= 1'b1;
		ev.host_fifo_write <= 1'b1;
		strobe();
		rchk("auth errors", error_flags_offset, 32'he1);
		cfg.authentication_command <= 1'b0;
		ev.command_start <= 1'b1;
		strobe();
		ev.in_response_window <= 1'b1;
		ev.host_fifo_write <= 1'b1;
		ev.miller_pulse_close <= 1'b1;
		strobe();
		rchk("window miller", error_flags_offset, 32'hc1);
		ev.in_response_window <= 1'b0;
		ev.receiver_start <= 1'b1;
		cfg.auto_anticollision_command <= 1'b1;
		cfg.initiator <= 1'b1;
		strobe();
		rchk("initiator", error_flags_offset, 32'hc1);
		cfg.initiator <= 1'b0;
		cfg.auto_anticollision_command <= 1'b0;
		apb(1'b0, 12'h100, 32'h0);
		check("unmapped err", 32'h1, {31'h0, err});
		check("unmapped data", 32'h0, rd);
		check("ready", 32'h1, {31'h0, pready});
		test_done();
	end
endmodule
